// *** verilog/celt_pkg.sv ***
// celt_pkg: constants shared by the correctable-error decay timer and its divider.
// assumes: single memory clock domain; config register reached by its documented offset.
`default_nettype none

package celt_pkg;

  // ------------------------------------------------------------------
  // counter geometry
  // ------------------------------------------------------------------
  localparam int unsigned FULL_W = 53;      // whole decay counter
  localparam int unsigned LOW_W = 11;       // hidden low section
  localparam int unsigned UPPER_W = 42;     // software-visible pair
  localparam int unsigned LOWWORD_W = 32;   // low word of the pair
  localparam int unsigned HIGHWORD_W = 10;  // high word of the pair
  localparam logic [LOW_W-1:0] LOW_MAX = 11'h7FF;
  localparam logic [LOW_W-1:0] LOW_ONE = 11'h001;
  localparam logic [UPPER_W-1:0] UPPER_ONE = 42'h00000000001;

  // ------------------------------------------------------------------
  // config register
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 12'h928;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h00000000;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned HI_LSB = 6;
  localparam int unsigned HI_MSB = 11;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned LO_MSB = 5;
  localparam int unsigned LIM_LSB = 12;
  localparam int unsigned LIM_MSB = 13;
  localparam logic [SEL_W-1:0] SEL_MIN = 6'h01;  // counter-pair bit 1, full bit 12
  localparam logic [SEL_W-1:0] SEL_MAX = 6'h29;  // counter-pair bit 41, full bit 52

  // ------------------------------------------------------------------
  // secondary divider
  // ------------------------------------------------------------------
  localparam int unsigned LIM_W = 2;
  localparam logic [LIM_W-1:0] LIM_DEFAULT = 2'h0;  // one pulse per four strobes
  localparam logic [LIM_W-1:0] DIV_ZERO = 2'h0;
  localparam logic [LIM_W-1:0] DIV_ONE = 2'h1;
  localparam logic [LIM_W-1:0] DIV_LAST_DEFAULT = 2'h3;

endpackage : celt_pkg

`default_nettype wire

// *** verilog/celt_secondary_divider.sv ***
// celt_secondary_divider: divides primary decay strobes into decay pulses.
// assumes: strobe is a one-cycle pulse from logic on the same clock.
`default_nettype none

module celt_secondary_divider
  import celt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // strobe side
  input wire logic strobeIn,
  input wire logic [LIM_W-1:0] secondaryStrobeLimit,
  // decay side
  output logic decayPulse
);

  logic [LIM_W-1:0] secondaryStrobeCounter;
  logic [LIM_W-1:0] next_secondaryStrobeCounter;
  logic next_decayPulse;
  logic [LIM_W-1:0] lastCount;

  // ------------------------------------------------------------------
  // divider
  // ------------------------------------------------------------------
  // code 00 wraps at 3 (four strobes), codes 1..3 wrap after that many strobes
  always_comb begin
    lastCount = (secondaryStrobeLimit == LIM_DEFAULT) ? DIV_LAST_DEFAULT : secondaryStrobeLimit - DIV_ONE;
    next_secondaryStrobeCounter = secondaryStrobeCounter;
    next_decayPulse = 1'b0;
    if (strobeIn) begin
      if (secondaryStrobeCounter >= lastCount) begin
        // >= so a limit lowered mid-count cannot strand the counter
        next_secondaryStrobeCounter = DIV_ZERO;
        next_decayPulse = 1'b1;
      end else begin
        next_secondaryStrobeCounter = secondaryStrobeCounter + DIV_ONE;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      secondaryStrobeCounter <= DIV_ZERO;
      decayPulse <= 1'b0;
    end else begin
      secondaryStrobeCounter <= next_secondaryStrobeCounter;
      decayPulse <= next_decayPulse;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_PULSE_NEEDS_STROBE: assert property (@(posedge clock) disable iff (rst)
    decayPulse |-> $past(strobeIn))
    else $error("decay pulse without a primary strobe");
  AST_DEFAULT_FOUR: assert property (@(posedge clock) disable iff (rst)
    (secondaryStrobeLimit == LIM_DEFAULT && strobeIn && secondaryStrobeCounter != DIV_LAST_DEFAULT)
      |=> !decayPulse)
    else $error("default limit pulsed before the fourth strobe");
  AST_LIMIT_ONE: assert property (@(posedge clock) disable iff (rst)
    (secondaryStrobeLimit == DIV_ONE && strobeIn) |=> decayPulse)
    else $error("limit one did not pulse on every strobe");

  COV_PULSE_DEFAULT: cover property (@(posedge clock) disable iff (rst)
    secondaryStrobeLimit == LIM_DEFAULT && decayPulse);
  COV_PULSE_LIMIT_THREE: cover property (@(posedge clock) disable iff (rst)
    secondaryStrobeLimit == 2'h3 && decayPulse);

endmodule : celt_secondary_divider

`default_nettype wire

// *** verilog/celt_decay_timer.sv ***
// celt_decay_timer: leaky-bucket decay timer feeding the correctable-error counter.
// assumes: config access strobes come from logic on the memory clock; one access per cycle.
//
// Behaviour
// - one 53-bit counter advances every memory clock
// - upper 42 bits are shown as a low word and a high word
// - upper 42 bits step only on the carry of the low 11-bit section
// - config holds high and low bit selects forming a two-hot mask
// - high select bits 11:6; code 01h is full bit 12; 00h, 2Ah-3Fh reserved
// - both selected bits set clears the whole counter and emits one strobe
// - strobes drive a 2-bit counter; reaching its limit emits one decay pulse
// - default limit 00b gives one pulse per four strobes
// - all-zero config means no decay at all
`default_nettype none

module celt_decay_timer
  import celt_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // config register access
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [ADDR_W-1:0] cfgAddr,
  input wire logic [DATA_W-1:0] cfgWrData,
  output logic [DATA_W-1:0] cfgRdData,
  // counter pair for software
  output logic [LOWWORD_W-1:0] decayTimerLowWord,
  output logic [HIGHWORD_W-1:0] decayTimerHighWord,
  // decay events
  output logic primaryStrobe,
  output logic decayPulse
);

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // reserved codes select nothing, so they can never produce a match
  function automatic logic [UPPER_W-1:0] selMask(input logic [SEL_W-1:0] code);
    logic [UPPER_W-1:0] mask;
    mask = '0;
    if (code >= SEL_MIN && code <= SEL_MAX) begin
      mask[code] = 1'b1;
    end
    return mask;
  endfunction : selMask

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [FULL_W-1:0] fullCount;
  logic [FULL_W-1:0] next_fullCount;
  logic [DATA_W-1:0] errorDecayConfig;
  logic [DATA_W-1:0] next_errorDecayConfig;
  logic [DATA_W-1:0] next_cfgRdData;
  logic [LOWWORD_W-1:0] next_decayTimerLowWord;
  logic [HIGHWORD_W-1:0] next_decayTimerHighWord;
  logic next_primaryStrobe;
  logic [LOW_W-1:0] lowCount;
  logic [UPPER_W-1:0] upperCount;
  logic [UPPER_W-1:0] nextUpper;
  logic [LOW_W-1:0] nextLow;
  logic [SEL_W-1:0] thresholdHighSelect;
  logic [SEL_W-1:0] thresholdLowSelect;
  logic [LIM_W-1:0] secondaryStrobeLimit;
  logic lowCarry;
  logic thresholdHit;
  logic cfgHit;
  logic [LIM_W-1:0] strobesSincePulse;
  logic [LIM_W-1:0] next_strobesSincePulse;

  // ------------------------------------------------------------------
  // counter and threshold compare
  // ------------------------------------------------------------------
  // the compare looks at the current count; the clear lands on the next edge
  always_comb begin
    lowCount = fullCount[LOW_W-1:0];
    upperCount = fullCount[FULL_W-1:LOW_W];
    thresholdHighSelect = errorDecayConfig[HI_MSB:HI_LSB];
    thresholdLowSelect = errorDecayConfig[LO_MSB:LO_LSB];
    secondaryStrobeLimit = errorDecayConfig[LIM_MSB:LIM_LSB];
    lowCarry = (lowCount == LOW_MAX);
    thresholdHit = (errorDecayConfig != CFG_RESET)
      && (|(upperCount & selMask(thresholdHighSelect)))
      && (|(upperCount & selMask(thresholdLowSelect)));
    nextLow = lowCount + LOW_ONE;
    nextUpper = lowCarry ? upperCount + UPPER_ONE : upperCount;
    if (thresholdHit) begin
      next_fullCount = '0;
    end else begin
      next_fullCount = {nextUpper, nextLow};
    end
    next_primaryStrobe = thresholdHit;
    // words track the counter in the same edge so software never sees skew
    next_decayTimerLowWord = next_fullCount[LOW_W+LOWWORD_W-1:LOW_W];
    next_decayTimerHighWord = next_fullCount[FULL_W-1:LOW_W+LOWWORD_W];
  end

  // ------------------------------------------------------------------
  // config register
  // ------------------------------------------------------------------
  // unmapped offsets read as zero and ignore writes
  always_comb begin
    cfgHit = (cfgAddr == CFG_OFFSET);
    next_errorDecayConfig = errorDecayConfig;
    next_cfgRdData = cfgRdData;
    if (cfgWrEn && cfgHit) begin
      next_errorDecayConfig = cfgWrData;
    end
    if (cfgRdEn) begin
      next_cfgRdData = cfgHit ? errorDecayConfig : CFG_RESET;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fullCount <= '0;
      errorDecayConfig <= CFG_RESET;
      cfgRdData <= CFG_RESET;
      decayTimerLowWord <= '0;
      decayTimerHighWord <= '0;
      primaryStrobe <= 1'b0;
    end else begin
      fullCount <= next_fullCount;
      errorDecayConfig <= next_errorDecayConfig;
      cfgRdData <= next_cfgRdData;
      decayTimerLowWord <= next_decayTimerLowWord;
      decayTimerHighWord <= next_decayTimerHighWord;
      primaryStrobe <= next_primaryStrobe;
    end
  end

  // ------------------------------------------------------------------
  // secondary divider
  // ------------------------------------------------------------------
  celt_secondary_divider u_divider (
    .clock(clock),
    .rst(rst),
    .strobeIn(primaryStrobe),
    .secondaryStrobeLimit(secondaryStrobeLimit),
    .decayPulse(decayPulse)
  );

  // ------------------------------------------------------------------
  // check helper
  // ------------------------------------------------------------------
  // counts primary strobes since the last decay pulse, seen from outside the divider,
  // so the limit checks below do not lean on the divider's own counter;
  // strobes are thousands of cycles apart, so a strobe never meets a pulse
  always_comb begin
    next_strobesSincePulse = strobesSincePulse;
    if (decayPulse) begin
      next_strobesSincePulse = DIV_ZERO;
    end else if (primaryStrobe && strobesSincePulse != DIV_LAST_DEFAULT) begin
      next_strobesSincePulse = strobesSincePulse + DIV_ONE; // saturates at three
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strobesSincePulse <= DIV_ZERO;
    end else begin
      strobesSincePulse <= next_strobesSincePulse;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_COUNT_ADVANCES: assert property (@(posedge clock) disable iff (rst)
    !thresholdHit |=> fullCount == $past(fullCount) + 1)
    else $error("decay counter did not advance by one");
  AST_WORDS_MATCH: assert property (@(posedge clock) disable iff (rst)
    {decayTimerHighWord, decayTimerLowWord} == fullCount[FULL_W-1:LOW_W])
    else $error("counter words differ from counter pair");
  AST_UPPER_ON_CARRY: assert property (@(posedge clock) disable iff (rst)
    ($past(!thresholdHit) && $changed(upperCount)) |-> $past(lowCount) == LOW_MAX)
    else $error("counter pair moved without a low carry");
  AST_STROBE_CAUSE: assert property (@(posedge clock) disable iff (rst)
    primaryStrobe |-> $past(|(upperCount & selMask(thresholdHighSelect))
      && |(upperCount & selMask(thresholdLowSelect))))
    else $error("strobe without both selected bits set");
  AST_RESERVED_HIGH: assert property (@(posedge clock) disable iff (rst)
    (thresholdHighSelect == 6'h00 || thresholdHighSelect > SEL_MAX) |=> !primaryStrobe)
    else $error("reserved high select produced a strobe");
  AST_HIT_CLEARS: assert property (@(posedge clock) disable iff (rst)
    thresholdHit |=> (fullCount == '0 && primaryStrobe) ##1 !primaryStrobe)
    else $error("match did not clear counter with one strobe");
  AST_ZERO_CFG_SILENT: assert property (@(posedge clock) disable iff (rst)
    (errorDecayConfig == CFG_RESET) [*2] |=> !decayPulse)
    else $error("decay pulse with zero config");
  AST_LOW_RESERVED: assert property (@(posedge clock) disable iff (rst)
    (thresholdLowSelect == 6'h00 || thresholdLowSelect > SEL_MAX) |=> !primaryStrobe)
    else $error("reserved low select produced a strobe");
  AST_READ_RETURNS: assert property (@(posedge clock) disable iff (rst)
    (cfgRdEn && cfgHit) |=> cfgRdData == $past(errorDecayConfig))
    else $error("config read did not return the register");
  AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (rst)
    (cfgWrEn && !cfgHit) |=> errorDecayConfig == $past(errorDecayConfig))
    else $error("write to another offset changed the config");

  // limit checks: the strobe that completes the count is followed by one pulse
  AST_DEFAULT_PULSE: assert property (@(posedge clock) disable iff (rst)
    (secondaryStrobeLimit == LIM_DEFAULT && primaryStrobe && strobesSincePulse == DIV_LAST_DEFAULT) |=> decayPulse)
    else $error("default limit did not pulse on the fourth strobe");
  AST_LIMIT_TWO: assert property (@(posedge clock) disable iff (rst)
    (secondaryStrobeLimit == 2'h2 && primaryStrobe && strobesSincePulse == DIV_ONE) |=> decayPulse)
    else $error("limit two did not pulse on the second strobe");
  AST_LIMIT_TWO_SKIP: assert property (@(posedge clock) disable iff (rst)
    (secondaryStrobeLimit == 2'h2 && primaryStrobe && strobesSincePulse == DIV_ZERO) |=> !decayPulse)
    else $error("limit two pulsed on the first strobe");
  AST_LIMIT_THREE: assert property (@(posedge clock) disable iff (rst)
    (secondaryStrobeLimit == 2'h3 && primaryStrobe && strobesSincePulse == 2'h2) |=> decayPulse)
    else $error("limit three did not pulse on the third strobe");

  COV_STROBE: cover property (@(posedge clock) disable iff (rst) primaryStrobe);
  COV_CARRY: cover property (@(posedge clock) disable iff (rst) lowCarry);
  COV_CFG_WRITE: cover property (@(posedge clock) disable iff (rst) cfgWrEn && cfgHit);

endmodule : celt_decay_timer

`default_nettype wire

// *** verification/celt_ce_counter_model.sv ***
// celt_ce_counter_model: correctable-error counter drained by the decay pulse.
// assumes: decayPulse is a one-cycle pulse on clock; load is driven by the bench.
`default_nettype none

module celt_ce_counter_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench side
  input wire logic load,
  input wire logic [15:0] loadValue,
  // decay side
  input wire logic decayPulse,
  output logic [15:0] ceCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] next_ceCount;

  // one step down per pulse; held at zero so an extra pulse is not hidden by a wrap
  always_comb begin
    next_ceCount = ceCount;
    if (load) begin
      next_ceCount = loadValue;
    end else if (decayPulse && ceCount != 16'h0000) begin
      next_ceCount = ceCount - 16'h0001;
    end
  end

  // register only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ceCount <= 16'h0000;
    end else begin
      ceCount <= next_ceCount;
    end
  end
endmodule : celt_ce_counter_model

`default_nettype wire

// *** verification/correctable_error_leak_timer_tb_top.sv ***
// correctable_error_leak_timer_tb_top: self-checking bench for the decay timer.
// assumes: 40 MHz clock; inputs change on the falling edge; one reset per row.
`default_nettype none

module correctable_error_leak_timer_tb_top;
  import celt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and row table
  // ----------------------------------------
  logic clock = 1'b0, rst = 1'b1, cfgWrEn = 1'b0, cfgRdEn = 1'b0, load = 1'b0;
  logic [ADDR_W-1:0] cfgAddr = 12'h000;
  logic [DATA_W-1:0] cfgWrData = 32'h00000000, cfgRdData, d;
  logic [LOWWORD_W-1:0] lowWord;
  logic [HIGHWORD_W-1:0] highWord;
  logic primaryStrobe, decayPulse;
  logic [15:0] ceCount;
  int fails = 0, nChecks = 0, gap;
  // both selects on full bit 12: count 0 to 1000h, then the clearing edge
  localparam int PERIOD = 4097;
  localparam logic [31:0] ROW_CFG [4] = '{32'h00000041, 32'h00001041, 32'h00002041, 32'h00003041};
  localparam int ROW_N [4] = '{5, 4, 5, 4}; // strobes watched after reset
  localparam logic [15:0] ROW_P [4] = '{16'h0001, 16'h0004, 16'h0002, 16'h0001};

  initial begin
    forever #12.5 clock = ~clock;
  end

  celt_decay_timer i_dut (.clock(clock), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .decayTimerLowWord(lowWord), .decayTimerHighWord(highWord),
    .primaryStrobe(primaryStrobe), .decayPulse(decayPulse));
  celt_ce_counter_model i_ce (.clock(clock), .rst(rst), .load(load), .loadValue(16'h0010),
    .decayPulse(decayPulse), .ceCount(ceCount));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [41:0] seen, input logic [41:0] exp, input string msg);
    nChecks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d, mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // reset also restarts the divider, so each row starts from a known count
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    load = 1'b1;
    @(negedge clock);
    load = 1'b0;
  endtask : do_reset

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    cfgAddr = a;
    cfgWrData = v;
    cfgWrEn = 1'b1;
    @(negedge clock);
    cfgWrEn = 1'b0;
    @(negedge clock); // idle cycle: a second call never re-raises the strobe in the same step
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    cfgAddr = a;
    cfgRdEn = 1'b1;
    @(negedge clock);
    cfgRdEn = 1'b0;
    v = cfgRdData;
    @(negedge clock); // idle cycle between accesses
  endtask : rd

  // bounded wait; gap is the number of cycles since the last call
  task automatic wait_strobe(output int g);
    g = 0;
    do begin
      @(negedge clock);
      g++;
    end while (primaryStrobe !== 1'b1 && g < 30000);
  endtask : wait_strobe

  task automatic quiet(input int n);
    int s;
    s = 0;
    repeat (n) begin
      @(negedge clock);
      if (primaryStrobe !== 1'b0 || decayPulse !== 1'b0) s++;
    end
    chk(s, 0, "unexpected decay event");
  endtask : quiet

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    // rows take about 74k cycles, idle and reserved tests about 17k more
    #2400000;
    fails++;
    close_out();
  end

  initial begin
    for (int r = 0; r < 4; r++) begin
      do_reset();
      wr(CFG_OFFSET, ROW_CFG[r]);
      wait_strobe(gap);
      for (int k = 1; k < ROW_N[r]; k++) begin
        wait_strobe(gap);
        chk(gap, PERIOD, "strobe spacing");
      end
      repeat (3) @(negedge clock);
      chk(ceCount, 16'h0010 - ROW_P[r], "decay pulse count");
      $display("row %0d done", r);
    end
    do_reset();
    rd(CFG_OFFSET, d);
    chk(d, 0, "config reset value");
    quiet(5000);
    chk(lowWord, 2, "low word");
    chk(highWord, 0, "high word");
    wr(CFG_OFFSET, 32'h00003FFF);
    wr(12'h92C, 32'hFFFFFFFF);
    rd(CFG_OFFSET, d);
    chk(d, 32'h00003FFF, "config readback");
    rd(12'h92C, d);
    chk(d, 0, "unmapped read");
    $display("register and idle test done");
    do_reset();
    // 6200 cycles: a decoder taking code 00h as pair bit 0 would first match at count 1800h
    wr(CFG_OFFSET, 32'h00000A81);
    quiet(6200);
    do_reset();
    wr(CFG_OFFSET, 32'h00000001);
    quiet(6200);
    $display("reserved select test done");
    close_out();
  end
endmodule : correctable_error_leak_timer_tb_top

`default_nettype wire
